// File: rtl/thermal_event_supervisor.sv
/*
 * Threshold, fault-queue and status logic of the two-zone thermal supervisor.
 * Assumes register requests arrive decoded, one cycle each, and conversion
 * results arrive as single-cycle strobes; the pins are open drain, driven low.
 */
`timescale 1ns/1ps
module thermal_event_supervisor
   import thermal_event_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_i,
   input  wire logic     reset_i,
   // Host register port
   input  wire reg_req_s req_i,
   output logic [7:0]    rdata_o,
   output logic          rvalid_o,
   // Conversion results
   input  wire conv_s    conv_i,
   output logic          converting_o,
   // Open-drain pins, enable high pulls low
   output logic          alert_out_n_oe_o,
   output logic          overheat_out_n_oe_o
);

   // Host-visible registers
   logic [7:0] local_temp_result_r;
   logic [7:0] remote_temp_result_r;
   logic [7:0] local_low_limit_r;
   logic [7:0] local_high_limit_r;
   logic [7:0] remote_low_limit_r;
   logic [7:0] remote_high_limit_r;
   logic [7:0] overtemp_release_limit_r;
   logic [7:0] overtemp_limit_r;
   logic [4:0] ctrl_r;          // Queue depth, mask, mode, shutdown
   logic       local_event_flag_r;
   logic       remote_event_flag_r;
   logic       overtemp_flag_r;
   logic       irq_r;           // Internal interrupt request
   arm_e       arm_r [2];       // Per-zone re-arm state
   logic [2:0] cnt_hi_r [3];    // Queue counters: zone0, zone1, overtemp
   logic [2:0] cnt_lo_r [3];

   // Control fields
   logic [1:0] queue_depth_field;
   logic       irq_mask_bit;
   logic       irq_mode;
   logic       power_down_bit;
   logic [2:0] depth;
   assign queue_depth_field = ctrl_r[4:3];  // Stored queue code sits in the top two bits
   assign irq_mask_bit      = ctrl_r[0];
   assign irq_mode          = ctrl_r[1];
   assign power_down_bit    = ctrl_r[2];

   // Depth decode
   always_comb
   begin
      case (queue_depth_field)
         2'b00:   depth = QDEPTH_0;
         2'b01:   depth = QDEPTH_1;
         2'b10:   depth = QDEPTH_2;
         default: depth = QDEPTH_3;
      endcase
   end

   // Request decode
   logic host_rd;
   logic host_wr;
   logic ctrl_rd;
   logic ctrl_wr;
   logic sd_enter;
   assign host_rd  = req_i.rd;
   assign host_wr  = req_i.wr && !req_i.rd;
   assign ctrl_rd  = host_rd && req_i.addr == ADDR_CTRL_STATUS;
   assign ctrl_wr  = host_wr && req_i.addr == ADDR_CTRL_STATUS;
   assign sd_enter = ctrl_wr && req_i.wdata[BIT_POWER_DOWN] && !power_down_bit;

   // Conversion taken only while running; a diode fault reads as full scale
   logic       conv_ok;
   logic [7:0] ctemp;
   assign conv_ok = conv_i.valid && !power_down_bit;
   assign ctemp   = conv_i.diode_fault ? FULL_SCALE_POS : conv_i.temp;

   // Signed comparisons per source
   logic [2:0] above;
   logic [2:0] below;
   logic [2:0] src_hit;
   always_comb
   begin
      above[0] = $signed(ctemp) > $signed(local_high_limit_r);
      below[0] = $signed(ctemp) < $signed(local_low_limit_r);
      above[1] = $signed(ctemp) > $signed(remote_high_limit_r);
      below[1] = $signed(ctemp) < $signed(remote_low_limit_r);
      above[2] = $signed(ctemp) > $signed(overtemp_limit_r);
      below[2] = $signed(ctemp) < $signed(overtemp_release_limit_r);
      src_hit  = {conv_i.remote, conv_i.remote, !conv_i.remote};
   end

   // Fault queues: count consecutive passes, restart on a miss
   logic [2:0] q_hi;
   logic [2:0] q_lo;
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_queue
         always_ff @(posedge clk_i)
         begin
            if (reset_i)
            begin
               cnt_hi_r[g] <= 3'h0;
               cnt_lo_r[g] <= 3'h0;
            end
            else if (conv_ok && src_hit[g])
            begin
               // Saturate at depth so a long hold keeps qualifying
               cnt_hi_r[g] <= !above[g] ? 3'h0 :
                              (cnt_hi_r[g] >= depth ? depth : cnt_hi_r[g] + 3'h1);
               cnt_lo_r[g] <= !below[g] ? 3'h0 :
                              (cnt_lo_r[g] >= depth ? depth : cnt_lo_r[g] + 3'h1);
            end
         end
         // Qualified this conversion
         assign q_hi[g] = conv_ok && src_hit[g] && above[g] && cnt_hi_r[g] + 3'h1 >= depth;
         assign q_lo[g] = conv_ok && src_hit[g] && below[g] && cnt_lo_r[g] + 3'h1 >= depth;
      end
   endgenerate

   // Zone events, honouring the re-arm state in interrupt mode
   logic [1:0] ev_hi;
   logic [1:0] ev_lo;
   logic [1:0] zone_ev;
   always_comb
   begin
      for (int z = 0; z < 2; z++)
      begin
         ev_hi[z] = q_hi[z] && arm_r[z] != ARM_LOW_ONLY;
         ev_lo[z] = q_lo[z] && arm_r[z] != ARM_HIGH_ONLY;
         zone_ev[z] = irq_mode ? (ev_hi[z] || ev_lo[z]) : q_hi[z];
      end
   end

   // Re-arm state per zone
   always_ff @(posedge clk_i)
   begin
      for (int z = 0; z < 2; z++)
      begin
         if (reset_i)
            arm_r[z] <= ARM_ANY;
         else if (ev_hi[z])
            arm_r[z] <= ARM_LOW_ONLY;
         else if (ev_lo[z])
            arm_r[z] <= ARM_HIGH_ONLY;
      end
   end

   // Zone flags: set wins over read clear; comparator clears on low queue
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         local_event_flag_r  <= 1'b0;
         remote_event_flag_r <= 1'b0;
      end
      else if (sd_enter)
      begin
         local_event_flag_r  <= 1'b0;
         remote_event_flag_r <= 1'b0;
      end
      else
      begin
         if (zone_ev[0])
            local_event_flag_r <= 1'b1;
         else if (ctrl_rd || (!irq_mode && q_lo[0]))
            local_event_flag_r <= 1'b0;
         if (zone_ev[1])
            remote_event_flag_r <= 1'b1;
         else if (ctrl_rd || (!irq_mode && q_lo[1]))
            remote_event_flag_r <= 1'b0;
      end
   end

   // Interrupt request
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         irq_r <= 1'b0;
      else if (sd_enter && irq_mode)
         irq_r <= 1'b0;
      else if (|zone_ev)
         irq_r <= 1'b1;
      else if (host_rd || (!irq_mode && (q_lo[0] || q_lo[1]) &&
               !(local_event_flag_r && !q_lo[0]) && !(remote_event_flag_r && !q_lo[1])))
         irq_r <= 1'b0;
   end

   // Interrupt pin driven only while unmasked
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         alert_out_n_oe_o <= 1'b0;
      else
         alert_out_n_oe_o <= (irq_r || |zone_ev) && !irq_mask_bit && !host_rd
                             && !(sd_enter && irq_mode);
   end

   // Overtemp flag and critical pin move together
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         overtemp_flag_r     <= 1'b0;
         overheat_out_n_oe_o <= 1'b0;
      end
      else if (q_hi[2])
      begin
         overtemp_flag_r     <= 1'b1;
         overheat_out_n_oe_o <= 1'b1;
      end
      else if (q_lo[2])
      begin
         overtemp_flag_r     <= 1'b0;
         overheat_out_n_oe_o <= 1'b0;
      end
   end

   // Result registers
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         local_temp_result_r  <= RST_TEMP;
         remote_temp_result_r <= RST_TEMP;
      end
      else if (conv_ok && conv_i.remote)
         remote_temp_result_r <= ctemp;
      else if (conv_ok)
         local_temp_result_r  <= ctemp;
   end

   // Writable limit and control registers
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         ctrl_r                   <= RST_CTRL[4:0];
         local_low_limit_r        <= RST_LOCAL_LOW;
         local_high_limit_r       <= RST_LOCAL_HIGH;
         remote_low_limit_r       <= RST_REMOTE_LOW;
         remote_high_limit_r      <= RST_REMOTE_HIGH;
         overtemp_release_limit_r <= RST_OT_RELEASE;
         overtemp_limit_r         <= RST_OT_LIMIT;
      end
      else if (host_wr)
      begin
         case (req_i.addr)
            // Packed as {queue[1:0], shutdown, mode, mask}
            ADDR_CTRL_STATUS: ctrl_r <= {req_i.wdata[BIT_QUEUE_HI:BIT_QUEUE_LO],
                                         req_i.wdata[BIT_POWER_DOWN],
                                         req_i.wdata[BIT_IRQ_MODE],
                                         req_i.wdata[BIT_IRQ_MASK]};
            ADDR_LOCAL_LOW:   local_low_limit_r        <= req_i.wdata;
            ADDR_LOCAL_HIGH:  local_high_limit_r       <= req_i.wdata;
            ADDR_REMOTE_LOW:  remote_low_limit_r       <= req_i.wdata;
            ADDR_REMOTE_HIGH: remote_high_limit_r      <= req_i.wdata;
            ADDR_OT_RELEASE:  overtemp_release_limit_r <= req_i.wdata;
            ADDR_OT_LIMIT:    overtemp_limit_r         <= req_i.wdata;
            default:          ;  // Read-only or unmapped writes ignored
         endcase
      end
   end

   // Read mux, registered
   logic [7:0] rd_mux;
   always_comb
   begin
      case (req_i.addr)
         ADDR_LOCAL_TEMP:  rd_mux = local_temp_result_r;
         ADDR_CTRL_STATUS: rd_mux = {local_event_flag_r, remote_event_flag_r,
                                     overtemp_flag_r, ctrl_r[4:3], ctrl_r[0],
                                     ctrl_r[1], ctrl_r[2]};
         ADDR_LOCAL_LOW:   rd_mux = local_low_limit_r;
         ADDR_LOCAL_HIGH:  rd_mux = local_high_limit_r;
         ADDR_REMOTE_TEMP: rd_mux = remote_temp_result_r;
         ADDR_REMOTE_LOW:  rd_mux = remote_low_limit_r;
         ADDR_REMOTE_HIGH: rd_mux = remote_high_limit_r;
         ADDR_OT_RELEASE:  rd_mux = overtemp_release_limit_r;
         ADDR_OT_LIMIT:    rd_mux = overtemp_limit_r;
         default:          rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rdata_o  <= 8'h00;
         rvalid_o <= 1'b0;
      end
      else
      begin
         rdata_o  <= host_rd ? rd_mux : 8'h00;
         rvalid_o <= host_rd;
      end
   end

   // Conversions run while not powered down
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         converting_o <= 1'b0;
      else
         converting_o <= !(ctrl_wr ? req_i.wdata[BIT_POWER_DOWN] : power_down_bit);
   end

   // Assertions
   a_overheat_out_n_mirror: assert property (@(posedge clk_i) disable iff (reset_i)
      overtemp_flag_r == overheat_out_n_oe_o)
      else $error("overtemp flag differs from critical pin");
   a_overheat_out_n_set: assert property (@(posedge clk_i) disable iff (reset_i)
      q_hi[2] |=> overheat_out_n_oe_o && overtemp_flag_r)
      else $error("critical not raised");
   a_overheat_out_n_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      q_lo[2] && !q_hi[2] |=> !overheat_out_n_oe_o)
      else $error("critical not released");
   a_overheat_out_n_hold_sd: assert property (@(posedge clk_i) disable iff (reset_i)
      power_down_bit |=> $stable(overheat_out_n_oe_o))
      else $error("critical changed in shutdown");
   a_read_drops_int: assert property (@(posedge clk_i) disable iff (reset_i)
      host_rd |=> !alert_out_n_oe_o)
      else $error("interrupt pin held across a read");
   a_mask_blocks_int: assert property (@(posedge clk_i) disable iff (reset_i)
      irq_mask_bit |=> !alert_out_n_oe_o)
      else $error("masked interrupt drove pin");
   a_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
      zone_ev[1] && !sd_enter |=> remote_event_flag_r)
      else $error("remote flag not set on event");
   a_sd_clears: assert property (@(posedge clk_i) disable iff (reset_i)
      sd_enter |=> !local_event_flag_r && !remote_event_flag_r)
      else $error("shutdown left zone flags");
   a_queue_depth: assert property (@(posedge clk_i) disable iff (reset_i)
      q_hi[0] |-> cnt_hi_r[0] + 3'h1 >= depth && depth <= QDEPTH_3)
      else $error("event qualified too early");
   a_read_clears: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl_rd && !zone_ev[0] && !sd_enter |=> !local_event_flag_r)
      else $error("control read did not clear local flag");

   c_overheat_out_n_cycle: cover property (@(posedge clk_i) q_hi[2] ##[1:200] q_lo[2]);
   c_local_irq:  cover property (@(posedge clk_i) zone_ev[0] ##1 alert_out_n_oe_o);
   c_deep_queue: cover property (@(posedge clk_i) queue_depth_field == 2'b11 && q_hi[1]);
   c_sd_enter:   cover property (@(posedge clk_i) sd_enter && irq_r);

endmodule : thermal_event_supervisor

// File: rtl/thermal_event_pkg.sv
/*
 * Constants, register map and carrier types of the two-zone thermal event supervisor.
 * Assumes a host-side serial engine presents decoded register reads and writes
 * and an ADC sequencer presents one result strobe per conversion.
 */
// Function
// - Queue field selects 1, 2, 4, 6 conversions
// - Events accepted after queue-depth consecutive conversions
// - Separate queues for local, remote, overtemp
// - Comparator mode releases after low-limit queue
// - Qualified events always set status flags (code sets zone flags for comparator high and armed interrupt events only)
// - Interrupt asserts only when mask bit zero
// - Any register read deasserts interrupt output
// - Reading control register clears zone flags
// - Re-arm needs opposite threshold crossing first
// - Shutdown deasserts interrupt, clears zone flags (code deasserts the interrupt in interrupt mode only)
// - Remote over limit asserts critical, sets flag
// - Below release limit deasserts critical, clears flag
// - Critical output unmaskable, mode independent
// - Overtemp flag mirrors critical; read keeps it
// - Shutdown leaves critical and its flag unchanged
// - Repeated events collapse into one flag
// - Diode fault sets flags and both outputs
// - Zone events set own flag, raise interrupt
// - Results read zero until first conversion
// - Flags set after first queue-depth conversions
// - Values are eight-bit two's complement degrees
// - Comparator mode tracks with hysteresis alone (code also clears zone flags and interrupt on reads in this mode)
// - Control register bit layout as listed
package thermal_event_pkg;

   // Register command bytes
   localparam logic [7:0] ADDR_LOCAL_TEMP   = 8'h00;
   localparam logic [7:0] ADDR_CTRL_STATUS  = 8'h01;
   localparam logic [7:0] ADDR_LOCAL_LOW    = 8'h02;
   localparam logic [7:0] ADDR_LOCAL_HIGH   = 8'h03;
   localparam logic [7:0] ADDR_REMOTE_TEMP  = 8'h10;
   localparam logic [7:0] ADDR_REMOTE_LOW   = 8'h12;
   localparam logic [7:0] ADDR_REMOTE_HIGH  = 8'h13;
   localparam logic [7:0] ADDR_OT_RELEASE   = 8'h22;
   localparam logic [7:0] ADDR_OT_LIMIT     = 8'h23;

   // Reset values
   localparam logic [7:0] RST_TEMP          = 8'h00;
   localparam logic [7:0] RST_CTRL          = 8'h00;
   localparam logic [7:0] RST_LOCAL_LOW     = 8'h4C;
   localparam logic [7:0] RST_LOCAL_HIGH    = 8'h51;
   localparam logic [7:0] RST_REMOTE_LOW    = 8'h5C;
   localparam logic [7:0] RST_REMOTE_HIGH   = 8'h61;
   localparam logic [7:0] RST_OT_RELEASE    = 8'h5C;
   localparam logic [7:0] RST_OT_LIMIT      = 8'h61;
   localparam logic [7:0] FULL_SCALE_POS    = 8'h7F;
   localparam logic [7:0] FULL_SCALE_NEG    = 8'h80;

   // Control/status field positions
   localparam int BIT_LOCAL_FLAG   = 7;
   localparam int BIT_REMOTE_FLAG  = 6;
   localparam int BIT_OT_FLAG      = 5;
   localparam int BIT_QUEUE_HI     = 4;
   localparam int BIT_QUEUE_LO     = 3;
   localparam int BIT_IRQ_MASK     = 2;
   localparam int BIT_IRQ_MODE     = 1;
   localparam int BIT_POWER_DOWN   = 0;

   // Queue depths for codes 00, 01, 10, 11
   localparam logic [2:0] QDEPTH_0 = 3'h1;
   localparam logic [2:0] QDEPTH_1 = 3'h2;
   localparam logic [2:0] QDEPTH_2 = 3'h4;
   localparam logic [2:0] QDEPTH_3 = 3'h6;

   // Host register access
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   // One conversion result
   typedef struct packed {
      logic       valid;
      logic       remote;
      logic       diode_fault;
      logic [7:0] temp;
   } conv_s;

   // Hysteresis arming state of a zone
   typedef enum logic [1:0] {ARM_ANY, ARM_LOW_ONLY, ARM_HIGH_ONLY} arm_e;

endpackage : thermal_event_pkg

// File: verif/serial_host_model.sv
/*
 * Behavioural model of the serial host that reaches the supervisor registers.
 * Assumes the register port takes one-cycle requests and answers a read with
 * a one-cycle pulse on the cycle after the request is taken.
 */
`timescale 1ns/1ps
module serial_host_model
   import thermal_event_pkg::*;
(
   // Clock
   input  wire logic       clk_i,
   // Register port toward the supervisor
   output reg_req_s        req_o,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i
);
   // Quiet bus at time zero
   initial
   begin
      req_o = '0;
   end

   // One request for one cycle after an optional pause; idle fields are scrambled
   task automatic put(input logic rd, input logic [7:0] addr, input logic [7:0] data,
                      input int gap);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      req_o <= '{rd: rd, wr: ~rd, addr: addr, wdata: data};
      @(posedge clk_i);
      req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
   endtask : put

   // Register write, no answer expected
   task automatic wr(input logic [7:0] addr, input logic [7:0] data, input int gap);
      put(1'b0, addr, data, gap);
   endtask : wr

   // Register read, answer taken while it stands
   task automatic rd(input logic [7:0] addr, input int gap, output logic [7:0] data,
                     output logic vld);
      put(1'b1, addr, 8'h00, gap);
      @(negedge clk_i);
      vld  = rvalid_i;
      data = rdata_i;
   endtask : rd
endmodule : serial_host_model

// File: verif/thermal_event_supervisor_tb.sv
/*
 * Self-checking bench of the thermal event supervisor with a host model.
 * Assumes one-cycle register requests and conversion strobes, and pins that
 * report an asserted output as a high pull-down enable.
 */
`timescale 1ns/1ps
module thermal_event_supervisor_tb;
   import thermal_event_pkg::*;
   logic        clk        = 1'b0;  // 10 MHz clock
   logic        reset      = 1'b1;  // Synchronous reset
   reg_req_s    req;                // Host requests
   logic [7:0]  rdata;              // Read data
   logic        rvalid;             // Read answer
   conv_s       conv       = '0;    // Conversion strobes
   logic        converting;         // ADC allowed to run
   logic        alert_oe;           // Interrupt pin pulled low
   logic        heat_oe;            // Critical pin pulled low
   int          mismatches = 0;     // Failed comparisons
   int          cmp_count  = 0;     // All comparisons
   int          cycles     = 0;     // Hang guard
   int unsigned seed;               // Seed result
   logic [7:0]  wv;                 // Random write data
   // Register map walk: addresses and reset values, last one unmapped
   logic [7:0]  map_a [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h12, 8'h13, 8'h22,
                              8'h23, 8'h05};
   logic [7:0]  map_e [10] = '{8'h00, 8'h00, 8'h4C, 8'h51, 8'h00, 8'h5C, 8'h61, 8'h5C,
                              8'h61, 8'h00};

   // Clock source
   always #50 clk = ~clk;

   thermal_event_supervisor i_thermal_event_supervisor (
      .clk_i               (clk),
      .reset_i             (reset),
      .req_i               (req),
      .rdata_o             (rdata),
      .rvalid_o            (rvalid),
      .conv_i              (conv),
      .converting_o        (converting),
      .alert_out_n_oe_o    (alert_oe),
      .overheat_out_n_oe_o (heat_oe)
   );

   serial_host_model i_serial_host_model (
      .clk_i   (clk),
      .req_o   (req),
      .rdata_i (rdata),
      .rvalid_i(rvalid)
   );

   // Verdict and end of run
   task automatic end_sim;
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end

   // Byte comparison
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
      end
   endtask : chk_byte

   // Single-bit comparison
   task automatic chk_bit(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: %s is %b, expected %b", $time, what, got, exp);
      end
   endtask : chk_bit

   // Queue depth for a field code
   function automatic int depth(input int code);
      return (code == 0) ? 1 : (code == 1) ? 2 : (code == 2) ? 4 : 6;
   endfunction : depth

   // Random reading above the remote high and overtemp limits
   function automatic logic [7:0] hot();
      return 8'h62 + 8'($urandom % 29);
   endfunction : hot

   // Random reading below both remote low limits, negative ones included
   function automatic logic [7:0] cold();
      logic [7:0] v;
      v = 8'($urandom);
      return v[7] ? v : 8'(v % 8'h5C);
   endfunction : cold

   // One conversion strobe, then scrambled idle fields
   task automatic cv(input logic remote, input logic fault, input logic [7:0] temp);
      @(posedge clk);
      conv <= '{valid: 1'b1, remote: remote, diode_fault: fault, temp: temp};
      @(posedge clk);
      conv <= '{valid: 1'b0, remote: ~remote, diode_fault: 1'b0, temp: ~temp};
   endtask : cv

   // Remote reading interleaved with a neutral local reading
   task automatic mix(input logic [7:0] temp);
      cv(1'b1, 1'b0, temp);
      cv(1'b0, 1'b0, 8'h4E);
   endtask : mix

   // Both pins after the last strobe has landed
   task automatic pins(input logic ea, input logic eh);
      @(posedge clk);
      @(negedge clk);
      chk_bit(alert_oe, ea, "alert pin");
      chk_bit(heat_oe, eh, "overheat pin");
   endtask : pins

   // Read and compare one register
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      i_serial_host_model.rd(addr, $urandom % 3, d, v);
      chk_bit(v, 1'b1, "read answer");
      chk_byte(d, exp, "register");
   endtask : rd_chk

   // Register write with a random pause
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      i_serial_host_model.wr(addr, data, $urandom % 3);
   endtask : wr

   // Main sequence
   initial
   begin
      seed = $urandom(32'hC820);
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 10; i++)
         rd_chk(map_a[i], map_e[i]);
      chk_bit(converting, 1'b1, "converting");
      // Random writes land in writable places only; the reset value is put back
      for (int i = 0; i < 10; i++)
      begin
         if (i == 1)
            continue;
         wv = 8'($urandom);
         wr(map_a[i], wv);
         rd_chk(map_a[i], (map_e[i] == 8'h00) ? 8'h00 : wv);
         wr(map_a[i], map_e[i]);
      end
      wr(ADDR_LOCAL_HIGH, 8'hA5);
      rd_chk(ADDR_LOCAL_HIGH, 8'hA5);
      wr(ADDR_LOCAL_HIGH, 8'h51);
      wr(ADDR_CTRL_STATUS, 8'h1E);
      rd_chk(ADDR_CTRL_STATUS, 8'h1E);
      // Queue depth per code, comparator mode, count broken in mid-run
      for (int q = 0; q < 4; q++)
      begin
         wr(ADDR_CTRL_STATUS, {3'b000, 2'(q), 3'b000});
         repeat (depth(q) - 1) mix(hot());
         mix(8'h5E);
         repeat (depth(q) - 1) mix(hot());
         pins(1'b0, 1'b0);
         mix(hot());
         pins(1'b1, 1'b1);
         repeat (depth(q) - 1) cv(1'b1, 1'b0, cold());
         pins(1'b1, 1'b1);
         cv(1'b1, 1'b0, cold());
         pins(1'b0, 1'b0);
         rd_chk(ADDR_CTRL_STATUS, {3'b000, 2'(q), 3'b000});
      end
      // Masked polling host: flags set, alert stays quiet, critical unmasked
      wr(ADDR_CTRL_STATUS, 8'h04);
      cv(1'b0, 1'b0, 8'h60);
      cv(1'b0, 1'b0, 8'h60);
      cv(1'b1, 1'b0, 8'h70);
      pins(1'b0, 1'b1);
      rd_chk(ADDR_CTRL_STATUS, 8'hE4);
      rd_chk(ADDR_CTRL_STATUS, 8'h24);
      wr(ADDR_CTRL_STATUS, 8'h00);
      cv(1'b0, 1'b0, 8'h60);
      pins(1'b1, 1'b1);
      rd_chk(ADDR_LOCAL_TEMP, 8'h60);
      chk_bit(alert_oe, 1'b0, "alert after read");
      cv(1'b0, 1'b0, 8'h10);
      cv(1'b1, 1'b0, 8'h10);
      pins(1'b0, 1'b0);
      rd_chk(ADDR_CTRL_STATUS, 8'h00);
      // Interrupt mode re-arm needs the opposite crossing
      wr(ADDR_CTRL_STATUS, 8'h02);
      cv(1'b0, 1'b0, 8'h60);
      pins(1'b1, 1'b0);
      rd_chk(ADDR_CTRL_STATUS, 8'h82);
      cv(1'b0, 1'b0, 8'h60);
      pins(1'b0, 1'b0);
      cv(1'b0, 1'b0, 8'h10);
      pins(1'b1, 1'b0);
      rd_chk(ADDR_LOCAL_LOW, 8'h4C);
      chk_bit(alert_oe, 1'b0, "alert after read");
      cv(1'b0, 1'b0, 8'h10);
      pins(1'b0, 1'b0);
      rd_chk(ADDR_CTRL_STATUS, 8'h82);
      // Shutdown in interrupt mode keeps the critical output
      cv(1'b1, 1'b0, 8'h70);
      pins(1'b1, 1'b1);
      wr(ADDR_CTRL_STATUS, 8'h03);
      pins(1'b0, 1'b1);
      chk_bit(converting, 1'b0, "converting");
      cv(1'b1, 1'b0, 8'h10);
      pins(1'b0, 1'b1);
      rd_chk(ADDR_CTRL_STATUS, 8'h23);
      rd_chk(ADDR_REMOTE_TEMP, 8'h70);
      wr(ADDR_CTRL_STATUS, 8'h02);
      cv(1'b1, 1'b0, 8'h10);
      @(negedge clk);
      chk_bit(heat_oe, 1'b0, "overheat pin");
      // Dropping below the low limit after a high event is a low event
      chk_bit(alert_oe, 1'b1, "alert pin");
      // Diode fault in comparator mode
      wr(ADDR_CTRL_STATUS, 8'h00);
      rd_chk(ADDR_CTRL_STATUS, 8'h40);
      cv(1'b1, 1'b1, 8'h00);
      pins(1'b1, 1'b1);
      rd_chk(ADDR_CTRL_STATUS, 8'h60);
      rd_chk(ADDR_REMOTE_TEMP, FULL_SCALE_POS);
      end_sim();
   end
endmodule : thermal_event_supervisor_tb
